// >>> core_clock_reset_control.sv
// Purpose: Clock and reset control for a processor core.
// Assumes: sys_clk_i is the input clock; the PLL itself is outside this block.
// Notes:   The PLL clock pin is a divided stand-in built from the input clock.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module core_clock_reset_control #(
    parameter int LOCK_CYCLES = core_clock_reset_pkg::LOCK_CYCLES
) (
    input  wire logic                                     sys_clk_i,
    input  wire logic                                     rst_i,
    input  wire logic                                     ext_reset_n_i,
    input  wire logic [core_clock_reset_pkg::STRAP_W-1:0] ratio_select_pins_i,
    input  wire logic [core_clock_reset_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [core_clock_reset_pkg::DATA_W-1:0]  reg_wdata_i,
    input  wire logic                                     reg_we_i,
    input  wire logic                                     reg_re_i,
    output logic      [core_clock_reset_pkg::DATA_W-1:0]  reg_rdata_o,
    output logic                                          core_reset_o,
    output logic                                          core_start_o,
    output logic      [31:0]                              core_fetch_addr_o,
    output logic                                          core_clk_from_pll_o,
    output logic      [core_clock_reset_pkg::MULT_W-1:0]  pll_mult_o,
    output logic      [core_clock_reset_pkg::DIV_W-1:0]   pll_div_o,
    output logic                                          shared_pin_o
);
    import core_clock_reset_pkg::*;

    localparam int CNT_W = $clog2(LOCK_CYCLES) + 1;

    function automatic logic [MULT_W-1:0] ratio_of(input logic [STRAP_W-1:0] code);
        logic [MULT_W-1:0] m;
        m = MULT_X1;
        unique case (code)
            STRAP_X3:     m = MULT_X3;
            STRAP_X16:    m = MULT_X16;
            STRAP_X8:     m = MULT_X8;
            STRAP_BYPASS: m = MULT_X1;
        endcase
        return m;
    endfunction

    function automatic logic pll_selected(input logic [STRAP_W-1:0] code);
        return code != STRAP_BYPASS;
    endfunction

    logic                 ext_n_sync;
    logic [STRAP_W-1:0]   strap_sync;
    core_state_type       state_q;
    logic [CNT_W-1:0]     lock_cnt_q;
    logic                 lock_done;
    logic [STRAP_W-1:0]   strap_q;
    logic [MULT_W-1:0]    mult_q;
    logic [DIV_W-1:0]     div_q;
    logic                 pin_sel_q;
    logic                 core_reset_q;
    logic                 core_start_q;
    logic [31:0]          fetch_addr_q;
    logic [DIV_W:0]       pll_div_cnt_q;
    logic                 pll_clk_q;
    logic                 shared_pin_q;
    logic [DATA_W-1:0]    rdata_q;
    logic                 pmc_write;

    // External reset and straps are pins, so they are synchronised first.
    two_flop_sync #(
        .WIDTH (1)
    ) u_reset_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (ext_reset_n_i),
        .sync_o    (ext_n_sync)
    );

    two_flop_sync #(
        .WIDTH (STRAP_W)
    ) u_strap_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   (ratio_select_pins_i),
        .sync_o    (strap_sync)
    );

    assign lock_done = (lock_cnt_q == CNT_W'(LOCK_CYCLES - 1));

    // The synchronised reset is only trusted as a level; a glitch is not filtered,
    // and one sampled low cycle returns the state to HELD, which the reset source must not rely on.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_q <= HELD;
        end else if (!ext_n_sync) begin
            state_q <= HELD;
        end else begin
            unique case (state_q)
                HELD:    state_q <= LOCKING;
                LOCKING: state_q <= lock_done ? RUNNING : LOCKING;
                RUNNING: state_q <= RUNNING;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i || state_q != LOCKING || !ext_n_sync) begin
            lock_cnt_q <= '0;
        end else if (!lock_done) begin
            lock_cnt_q <= lock_cnt_q + CNT_W'(1);
        end
    end

    // Straps follow the pins while held and freeze once reset is released.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            strap_q <= STRAP_RESET;
        end else if (state_q == HELD) begin
            strap_q <= strap_sync;
        end
    end

    assign pmc_write = reg_we_i && reg_addr_i == PMC_OFFSET && state_q == RUNNING;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mult_q    <= MULT_X3;
            div_q     <= DIV_RESET;
            pin_sel_q <= PIN_SEL_RESET;
        end else if (state_q == HELD) begin
            mult_q    <= ratio_of(strap_sync);
            div_q     <= DIV_RESET;
            pin_sel_q <= PIN_SEL_RESET;
        end else if (pmc_write) begin
            mult_q    <= reg_wdata_i[PMC_MULT_LSB +: MULT_W];
            div_q     <= reg_wdata_i[PMC_DIV_LSB +: DIV_W];
            pin_sel_q <= reg_wdata_i[PMC_PIN_SEL_BIT];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            core_reset_q <= 1'b1;
        end else begin
            core_reset_q <= !(ext_n_sync && (state_q == RUNNING ||
                            (state_q == LOCKING && lock_done)));
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            core_start_q <= 1'b0;
            fetch_addr_q <= RESET_VECTOR;
        end else begin
            core_start_q <= ext_n_sync && state_q == LOCKING && lock_done;
            fetch_addr_q <= RESET_VECTOR;
        end
    end

    // Stand-in PLL clock: toggles every div+1 input cycles so the pin shows activity.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || state_q == HELD) begin
            pll_div_cnt_q <= '0;
            pll_clk_q     <= 1'b0;
        end else if (pll_div_cnt_q >= {1'b0, div_q}) begin
            pll_div_cnt_q <= '0;
            pll_clk_q     <= !pll_clk_q;
        end else begin
            pll_div_cnt_q <= pll_div_cnt_q + (DIV_W + 1)'(1);
        end
    end

    // The pin is active low reset out, or pll_clk_q when pin_sel_q is set; registered so no mux glitch reaches it.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            shared_pin_q <= 1'b0;
        end else if (pin_sel_q) begin
            shared_pin_q <= pll_clk_q;
        end else begin
            shared_pin_q <= !core_reset_q;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else if (reg_re_i) begin
            rdata_q <= '0;
            unique case (reg_addr_i)
                PMC_OFFSET: begin
                    rdata_q[PMC_MULT_LSB +: MULT_W] <= mult_q;
                    rdata_q[PMC_DIV_LSB +: DIV_W]   <= div_q;
                    rdata_q[PMC_PIN_SEL_BIT]        <= pin_sel_q;
                end
                STATUS_OFFSET: begin
                    rdata_q[ST_STATE_LSB +: 2]       <= state_q;
                    rdata_q[ST_LOCKED_BIT]           <= state_q == RUNNING;
                    rdata_q[ST_STRAP_LSB +: STRAP_W] <= strap_q;
                    rdata_q[ST_PLL_SRC_BIT]          <= pll_selected(strap_q);
                end
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata_o         = rdata_q;
    assign core_reset_o        = core_reset_q;
    assign core_start_o        = core_start_q;
    assign core_fetch_addr_o   = fetch_addr_q;
    assign core_clk_from_pll_o = pll_selected(strap_q);
    assign pll_mult_o          = mult_q;
    assign pll_div_o           = div_q;
    assign shared_pin_o        = shared_pin_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_lock_end;
        state_q == LOCKING && lock_done && ext_n_sync;
    endsequence

    sequence s_core_up;
        !core_reset_o && core_start_o && core_fetch_addr_o == RESET_VECTOR;
    endsequence

    a_src_select: assert property (
        core_clk_from_pll_o == (strap_q != STRAP_BYPASS))
        else $error("core clock source disagrees with straps");

    a_strap_frozen: assert property (
        state_q != HELD && $past(state_q) != HELD |-> $stable(strap_q))
        else $error("straps changed after reset release");

    a_mult_startup: assert property (
        $past(state_q) == HELD && state_q == LOCKING
        |-> mult_q == ratio_of($past(strap_sync)))
        else $error("start-up multiplier does not match strap code");

    a_write_taken: assert property (
        reg_we_i && reg_addr_i == PMC_OFFSET && state_q == RUNNING && ext_n_sync
        |=> mult_q == $past(reg_wdata_i[5:0]) && div_q == $past(reg_wdata_i[9:6]))
        else $error("multiplier or divider write not taken");

    a_write_ignored: assert property (
        reg_we_i && state_q == LOCKING && ext_n_sync |=> $stable(mult_q) && $stable(div_q))
        else $error("control written before core left reset");

    a_pin_reset: assert property (
        !pin_sel_q |=> shared_pin_o == !$past(core_reset_o))
        else $error("shared pin does not follow core reset");

    a_pin_clock: assert property (
        pin_sel_q |=> shared_pin_o == $past(pll_clk_q))
        else $error("shared pin does not carry PLL clock");

    a_sel_default: assert property (
        state_q == HELD |=> !pin_sel_q)
        else $error("pin select not back to reset output");

    a_lock_hold: assert property (
        state_q != RUNNING |-> core_reset_o)
        else $error("core released before lock interval ended");

    a_lock_count: assert property (
        $past(state_q) == HELD && state_q == LOCKING && ext_n_sync
        |-> lock_cnt_q == '0 ##1 lock_cnt_q == CNT_W'(1))
        else $error("lock counter did not start from zero");

    a_lock_release: assert property (
        s_lock_end |=> s_core_up ##1 !core_start_o)
        else $error("core did not start at reset vector after lock");

    a_start_only_lock: assert property (
        $rose(core_start_o) |-> $past(state_q) == LOCKING && state_q == RUNNING)
        else $error("core start without lock interval");

    a_held_low: assert property (
        !ext_n_sync |-> ##[1:2] (state_q == HELD && core_reset_o))
        else $error("external reset did not hold the core");

    // Writes are refused until the core runs, so locking always keeps reset out.
    a_pin_default: assert property (
        state_q == LOCKING |-> !pin_sel_q)
        else $error("pin select left reset output during lock");

    a_run_released: assert property (
        state_q == RUNNING |-> !core_reset_o)
        else $error("core reset asserted while running");

    a_start_pulse: assert property (
        core_start_o |=> !core_start_o)
        else $error("core start longer than one cycle");

    a_pmc_readback: assert property (
        reg_re_i && reg_addr_i == PMC_OFFSET
        |=> reg_rdata_o[PMC_MULT_LSB +: MULT_W] == $past(mult_q)
            && reg_rdata_o[PMC_DIV_LSB +: DIV_W] == $past(div_q))
        else $error("multiplier or divider read back wrong");

endmodule

// >>> core_clock_reset_control_tb_top.sv
// Purpose: Self-checking bench for the core clock and reset controller.
// Assumes: Lock interval shortened to 16 cycles; expectations follow that value.
// Notes:   Random PMC values come from a bench LFSR with a fixed start value.
`timescale 1ns/1ps
module core_clock_reset_control_tb_top;
    import core_clock_reset_pkg::*;
    localparam int LOCK = 16;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hold = 1'b1;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic [1:0]  strap = 2'h0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        ext_n, pll_src, core_reset, core_start, shared_pin;
    logic [1:0]  pins;
    logic [3:0]  div, last_div;
    logic [5:0]  mult;
    logic [31:0] rdata, fetch, r;
    int          errors = 0;
    int          compares = 0;
    int unsigned lfsr_q = 67052;
    logic [31:0] pmc_model_q[$];

    always #12.5 clk = ~clk;

    reset_supervisor_model i_reset_supervisor_model (.sys_clk_i(clk), .hold_i(hold),
        .strap_i(strap), .ext_reset_n_o(ext_n), .ratio_select_pins_o(pins));
    core_clock_reset_control #(.LOCK_CYCLES(LOCK)) i_core_clock_reset_control (
        .sys_clk_i(clk), .rst_i(rst), .ext_reset_n_i(ext_n), .ratio_select_pins_i(pins),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
        .reg_rdata_o(rdata), .core_reset_o(core_reset), .core_start_o(core_start),
        .core_fetch_addr_o(fetch), .core_clk_from_pll_o(pll_src), .pll_mult_o(mult),
        .pll_div_o(div), .shared_pin_o(shared_pin));

    function automatic int unsigned lfsr_next(input int unsigned s);
        return (s >> 1) ^ (s[0] ? 32'h8020_0003 : 32'h0);
    endfunction

    function automatic logic [5:0] exp_mult(input logic [1:0] s);
        case (s)
            2'h0: return 6'h03;
            2'h1: return 6'h10;
            2'h2: return 6'h08;
            default: return 6'h01;
        endcase
    endfunction

    task automatic tally(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_pin(input logic [31:0] got, input logic [31:0] exp);
        tally(got, exp);
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        tally(got, exp);
    endtask

    task automatic report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic boot(input logic [1:0] s);
        int n;
        @(posedge clk);
        hold <= 1'b1;
        strap <= s;
        repeat (6) @(posedge clk);
        #1;
        check_pin(32'(mult), 32'(exp_mult(s)));
        check_pin(32'(core_reset), 32'h1);
        check_pin(32'(shared_pin), 32'h0);
        @(posedge clk);
        hold <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (core_reset === 1'b1 && n < LOCK + 20);
        // Two sync stages and the supervisor flop add a few cycles to the lock count.
        check_pin(32'(n >= LOCK && n <= LOCK + 5), 32'h1);
        check_pin(32'(core_start), 32'h1);
        check_pin(fetch, RESET_VECTOR);
        check_pin(32'(pll_src), 32'(s != 2'h3));
        @(posedge clk);
        #1;
        check_pin(32'(core_start), 32'h0);
        check_pin(32'(shared_pin), 32'h1);
        reg_read(STATUS_OFFSET, r);
        check_reg(r, 32'h6 | (32'(s) << 4) | (32'(s != 2'h3) << 6));
        $display("test boot strap %0d done", s);
    endtask

    task automatic run_pmc(input logic sel);
        logic [5:0]  m;
        logic [3:0]  d;
        logic [31:0] v;
        lfsr_q = lfsr_next(lfsr_q);
        m = 6'(lfsr_q % 63 + 1);
        d = {1'b0, lfsr_q[10:8]};
        last_div = d;
        v = {19'h0, sel, 2'h0, d, m};
        pmc_model_q.push_back(v);
        reg_write(PMC_OFFSET, v);
        #1;
        check_pin(32'(mult), 32'(m));
        check_pin(32'(div), 32'(d));
        reg_read(PMC_OFFSET, r);
        check_reg(r, pmc_model_q.pop_front());
        $display("test pmc select %0d done", sel);
    endtask

    task automatic clock_out;
        int  n;
        logic p;
        @(posedge clk);
        #1;
        p = shared_pin;
        n = 0;
        while (shared_pin === p && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        p = shared_pin;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (shared_pin === p && n < 40);
        check_pin(32'(n), 32'(last_div) + 32'h1);
        reg_read(4'h8, r);
        check_reg(r, 32'h0);
        $display("test clock out done");
    endtask

    task automatic abort_lock;
        @(posedge clk);
        hold <= 1'b1;
        repeat (6) @(posedge clk);
        reg_write(PMC_OFFSET, 32'h0000_103f);
        #1;
        check_pin(32'(mult), 32'(exp_mult(strap)));
        check_pin(32'(shared_pin), 32'h0);
        @(posedge clk);
        hold <= 1'b0;
        repeat (LOCK / 2 - 2) @(posedge clk);
        // A write in the lock interval must be refused like one under reset.
        reg_write(PMC_OFFSET, 32'h0000_103f);
        hold <= 1'b1;
        #1;
        check_pin(32'(mult), 32'(exp_mult(strap)));
        check_pin(32'(div), 32'h0);
        repeat (5) @(posedge clk);
        #1;
        check_pin(32'(core_reset), 32'h1);
        reg_read(STATUS_OFFSET, r);
        check_reg(r & 32'h3, 32'h0);
        $display("test abort lock done");
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            boot(2'(s));
            run_pmc(1'b0);
        end
        run_pmc(1'b1);
        clock_out();
        abort_lock();
        report_and_stop();
    end
endmodule

// >>> core_clock_reset_pkg.sv
// Purpose: Shared constants and types for the core clock and reset controller.
// Assumes: One system clock at 40 MHz standing in for the input clock pin.
// Notes:   Register offsets, field positions and reset values live here.
package core_clock_reset_pkg;

    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;
    localparam int          MULT_W          = 6;
    localparam int          DIV_W           = 4;
    localparam int          STRAP_W         = 2;

    // Register offsets on the plain register port.
    localparam logic [3:0]  PMC_OFFSET      = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET   = 4'h4;

    // Power-management control field positions.
    localparam int          PMC_MULT_LSB    = 0;
    localparam int          PMC_DIV_LSB     = 6;
    localparam int          PMC_PIN_SEL_BIT = 12;

    // Status field positions.
    localparam int          ST_STATE_LSB    = 0;
    localparam int          ST_LOCKED_BIT   = 2;
    localparam int          ST_STRAP_LSB    = 4;
    localparam int          ST_PLL_SRC_BIT  = 6;

    // Strap codes and the multipliers they select.
    localparam logic [1:0]  STRAP_X3        = 2'h0;
    localparam logic [1:0]  STRAP_X16       = 2'h1;
    localparam logic [1:0]  STRAP_X8        = 2'h2;
    localparam logic [1:0]  STRAP_BYPASS    = 2'h3;
    localparam logic [5:0]  MULT_X3         = 6'h03;
    localparam logic [5:0]  MULT_X16        = 6'h10;
    localparam logic [5:0]  MULT_X8         = 6'h08;
    localparam logic [5:0]  MULT_X1         = 6'h01;

    // Values after reset.
    localparam logic [3:0]  DIV_RESET       = 4'h0;
    localparam logic        PIN_SEL_RESET   = 1'b0;
    localparam logic [1:0]  STRAP_RESET     = 2'h0;

    // PLL lock interval in input-clock cycles.
    localparam int          LOCK_CYCLES     = 4096;

    // Hardware reset vector; the value is arbitrary.
    localparam logic [31:0] RESET_VECTOR    = 32'h0000_0100;

    typedef enum logic [1:0] {
        HELD,
        LOCKING,
        RUNNING
    } core_state_type;

endpackage

// >>> reset_supervisor_model.sv
// Purpose: Reset supervisor and strap source on the far side of the clock controller.
// Assumes: The bench asks for reset through hold_i and sets straps only while reset is held.
// Notes:   Outputs are registered so they move just after a rising clock edge.
`timescale 1ns/1ps
module reset_supervisor_model (
    input  wire logic       sys_clk_i,
    input  wire logic       hold_i,
    input  wire logic [1:0] strap_i,
    output logic            ext_reset_n_o,
    output logic [1:0]      ratio_select_pins_o
);
    // Reset is low from power-up, so the part never starts on an unsettled supply.
    initial begin
        ext_reset_n_o = 1'b0;
        ratio_select_pins_o = 2'h0;
    end
    always @(posedge sys_clk_i) begin
        ext_reset_n_o <= !hold_i;
        // Straps only move under reset, as a board with fixed straps would behave.
        if (hold_i) begin
            ratio_select_pins_o <= strap_i;
        end
    end
endmodule

// >>> two_flop_sync.sv
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Each bit is an independent slow level.
// Notes:   Only the second stage may be read by other logic.
`timescale 1ns/1ps
module two_flop_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule
